/* File: hdl/rfs_pkg.sv */
// Summary of operation
// - output above warning level halts switching; switching resumes back in regulation
// - warning level held within 106..116 percent; host keeps it below protection level
// - warning turns both switches off except boot refresh pulses on low-side; vendor mode keeps low-side on instead
// - power good low throughout soft-start and soft-shutdown
// - after soft-start, power good high whenever output is in regulation
// - power good rise level 84..98 percent, fall level 82..96 percent
// - power good low while output above protection level
// - sync master drives 45 percent duty clock rising at cycle start
// - sync slave starts cycle 200 ns after chosen sync edge
// - slave locks only after 64 consecutive valid sync cycles
// - sync period outside 20 percent window drops slave mode to internal clock
// - input over-voltage level 18..24 V, filtered, four selectable responses
// - switching begins only with input above turn-on level 4.5..10.5 V
// - shutdown when input falls below turn-off level 4..10 V
// - over-temperature from telemetry against 80..160 C, four selectable responses
// - thermal cutoff level shuts down at once, bias included, ignoring settings
// - boot under-voltage holds high-side off, pulses low-side until cleared
// - input or bias under-voltage stops switching and resets the block
// - output faults, switch node and start-up fault stop switching, then protect
// - peak current limits per cycle, protects after delay; extreme protects at once
// - telemetry values refreshed every 900 us
// - protection is hiccup retry after pause or latch-off until cleared or disabled
package rfs_pkg;
  localparam int          CLK_MHZ        = 250;
  localparam int          SYNC_LAG_NS    = 200;
  localparam int          SYNC_LAG_CYC   = (SYNC_LAG_NS * CLK_MHZ + 999) / 1000;
  localparam int          FILT_US        = 5;
  localparam int          FILT_CYC       = FILT_US * CLK_MHZ;
  localparam int          TELEM_US       = 900;
  localparam int          TELEM_CYC      = TELEM_US * CLK_MHZ;
  localparam int          HICCUP_S       = 1;
  localparam int          HICCUP_CYC     = HICCUP_S * CLK_MHZ * 1000000;
  localparam int          SYNC_VALID_N   = 64;
  localparam int          SYNC_WIN_PCT   = 20;
  localparam int          MASTER_DUTY    = 45;
  localparam int          PCT_FULL       = 100;
  // byte addresses of the register words
  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_VOUT_TGT     = 8'h04;
  localparam logic [7:0]  A_OUT_PCT      = 8'h08;
  localparam logic [7:0]  A_PG_PCT       = 8'h0c;
  localparam logic [7:0]  A_VIN_LIM      = 8'h10;
  localparam logic [7:0]  A_RESP         = 8'h14;
  localparam logic [7:0]  A_STATUS       = 8'h18;
  localparam logic [7:0]  A_TLM_V        = 8'h1c;
  localparam logic [7:0]  A_TLM_I        = 8'h20;
  localparam logic [7:0]  A_TLM_T        = 8'h24;
  // control bits
  localparam int          C_EN = 0, C_PULLDN = 1, C_MASTER = 2, C_PH180 = 3, C_SLAVE = 4;
  localparam int          C_CLR = 5;
  // programmable ranges; percent, 100 mV units for input, degrees C
  localparam logic [7:0]  OVW_LO = 8'h6a, OVW_HI = 8'h74, OVP_LO = 8'h6e, OVP_HI = 8'h7c;
  localparam logic [7:0]  UVP_LO = 8'h37, UVP_HI = 8'h5a;
  localparam logic [7:0]  PGR_LO = 8'h54, PGR_HI = 8'h62, PGF_LO = 8'h52, PGF_HI = 8'h60;
  localparam logic [7:0]  VOV_LO = 8'hb4, VOV_HI = 8'hf0, VON_LO = 8'h2d, VON_HI = 8'h69;
  localparam logic [7:0]  VOF_LO = 8'h28, VOF_HI = 8'h64, OT_LO = 8'h50, OT_HI = 8'ha0;
  // reset values
  localparam logic [31:0] RST_CTRL    = 32'h0000_0001;
  localparam logic [31:0] RST_VOUT    = 32'h0000_0320;
  localparam logic [31:0] RST_OUT_PCT = 32'h0037_6e6a;
  localparam logic [31:0] RST_PG_PCT  = 32'h0000_5254;
  localparam logic [31:0] RST_VIN_LIM = 32'h0028_2db4;
  localparam logic [31:0] RST_RESP    = 32'h0000_2aa0;
  // status flag positions
  localparam int F_OVW = 0, F_OVP = 1, F_UVP = 2, F_VIN_OV = 3, F_VIN_UV = 4, F_VCC_UV = 5;
  localparam int F_OT = 6, F_TSHDN = 7, F_BOOT = 8, F_AVG = 9, F_PEAK = 10, F_XPEAK = 11;
  localparam int F_SWN = 12, F_START = 13, F_SYNC = 14, NFLAG = 15;

  typedef enum logic [1:0] {R_IGNORE, R_RECOVER, R_HICCUP, R_LATCH} rfs_resp_e;

  // comparator and supervisor levels from the analogue side
  typedef struct packed {
    logic avg_oc;
    logic hs_peak;
    logic hs_extreme;
    logic sw_node;
    logic boot_uv;
    logic vcc_uv;
    logic tshdn;
  } rfs_cmp_s;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] iin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [7:0]  temp;
  } rfs_meas_s;
endpackage

/* File: hdl/rfs_top.sv */
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module rfs_top #(
  parameter int SW_PERIOD  = 500,
  parameter int SS_CYC     = 2000,
  parameter int PEAK_DLY   = 8,
  parameter int BOOT_PULSE = 20,
  parameter int TELEM_CYCP = rfs_pkg::TELEM_CYC,
  parameter int HICCUP_P   = rfs_pkg::HICCUP_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire rfs_pkg::rfs_cmp_s  cmp_i,
  input  wire rfs_pkg::rfs_meas_s meas_i,
  input  wire logic             sync_i,
  output logic                  sync_o,
  output logic                  sync_oe_o,
  output logic                  high_side_switch_o,
  output logic                  low_side_switch_o,
  output logic                  cycle_start_o,
  output logic                  power_good_output_o,
  output logic                  bias_off_o
);
  import rfs_pkg::*;

  typedef enum logic [2:0] {S_OFF, S_SOFT_START, S_RUN, S_SOFT_STOP, S_HICCUP, S_LATCHED} rfs_st_e;

  localparam int unsigned TW   = 28;
  localparam int unsigned SWW  = 12;
  localparam logic [SWW-1:0] PER      = SWW'(SW_PERIOD - 1);
  localparam logic [SWW-1:0] DUTY     = SWW'(SW_PERIOD * MASTER_DUTY / PCT_FULL);
  localparam logic [SWW-1:0] WIN_LO   = SWW'(SW_PERIOD * (PCT_FULL - SYNC_WIN_PCT) / PCT_FULL);
  localparam logic [SWW-1:0] WIN_HI   = SWW'(SW_PERIOD * (PCT_FULL + SYNC_WIN_PCT) / PCT_FULL);
  localparam logic [SWW-1:0] LAG      = SWW'(SYNC_LAG_CYC);
  localparam logic [TW-1:0]  T_SS     = TW'(SS_CYC);
  localparam logic [TW-1:0]  T_HIC    = TW'(HICCUP_P);
  localparam logic [TW-1:0]  T_TLM    = TW'(TELEM_CYCP);
  localparam logic [11:0]    T_FILT   = 12'(FILT_CYC);
  localparam logic [6:0]     VALID_N  = 7'(SYNC_VALID_N);
  localparam logic [7:0]     PEAK_N   = 8'(PEAK_DLY);
  localparam logic [SWW-1:0] BOOT_N   = SWW'(BOOT_PULSE);
  localparam logic [23:0]    HUNDRED  = 24'(PCT_FULL);

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [23:0] pct_of(input logic [15:0] t, input logic [7:0] p);
    pct_of = 24'(t) * 24'(p);
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  rfs_cmp_s cmp_m_q, cmp_q;
  logic     sync_m_q, sync_s_q, sync_d1_q;
  always_ff @(posedge clk_i) begin
    cmp_m_q   <= cmp_i;
    cmp_q     <= cmp_m_q;
    sync_m_q  <= sync_i;
    sync_s_q  <= sync_m_q;
    sync_d1_q <= sync_s_q;
  end

  // ------------------------------------------------------------
  // register file over wishbone
  // ------------------------------------------------------------
  logic [31:0]      ctrl_q, vtgt_q, opct_q, pgpct_q, vlim_q, resp_q;
  logic [NFLAG-1:0] stat_q, ev;
  logic             ack_q;
  logic [31:0]      rdat_q, rmux;
  rfs_meas_s        tlm_q;
  rfs_st_e          st_q;

  wire        acc    = wb_cyc_i && wb_stb_i && !ack_q;
  wire        wr     = acc && wb_we_i;
  wire [31:0] bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_ctl = wr && (wb_adr_i == A_CTRL);
  wire [31:0] ctl_w  = (ctrl_q & ~bmask) | (wb_dat_i & bmask);
  wire        clr_p  = wr_ctl && wb_sel_i[0] && wb_dat_i[C_CLR];
  wire [31:0] op_w   = (opct_q & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] pg_w   = (pgpct_q & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] vl_w   = (vlim_q & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] vt_w   = (vtgt_q & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] st_clr = (wr && (wb_adr_i == A_STATUS)) ? (wb_dat_i & bmask) : 32'h0;

  always_comb begin
    if (wb_adr_i == A_CTRL)          rmux = ctrl_q;
    else if (wb_adr_i == A_VOUT_TGT) rmux = vtgt_q;
    else if (wb_adr_i == A_OUT_PCT)  rmux = opct_q;
    else if (wb_adr_i == A_PG_PCT)   rmux = pgpct_q;
    else if (wb_adr_i == A_VIN_LIM)  rmux = vlim_q;
    else if (wb_adr_i == A_RESP)     rmux = resp_q;
    else if (wb_adr_i == A_STATUS)   rmux = {17'h0, stat_q};
    else if (wb_adr_i == A_TLM_V)    rmux = {tlm_q.vout, tlm_q.vin};
    else if (wb_adr_i == A_TLM_I)    rmux = {tlm_q.iout, tlm_q.iin};
    else if (wb_adr_i == A_TLM_T)    rmux = {21'h0, st_q, tlm_q.temp};
    else                             rmux = 32'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0;
      ctrl_q  <= RST_CTRL;
      vtgt_q  <= RST_VOUT;
      opct_q  <= RST_OUT_PCT;
      pgpct_q <= RST_PG_PCT;
      vlim_q  <= RST_VIN_LIM;
      resp_q  <= RST_RESP;
    end else begin
      ack_q  <= acc;
      rdat_q <= acc ? rmux : 32'h0;
      if (wr_ctl) ctrl_q <= {26'h0, 1'b0, ctl_w[4:0]};
      if (wr && (wb_adr_i == A_VOUT_TGT)) vtgt_q <= {16'h0, vt_w[15:0]};
      if (wr && (wb_adr_i == A_OUT_PCT)) begin
        opct_q <= {8'h0, clamp(op_w[23:16], UVP_LO, UVP_HI), clamp(op_w[15:8], OVP_LO, OVP_HI),
                   clamp(op_w[7:0], OVW_LO, OVW_HI)};
      end
      if (wr && (wb_adr_i == A_PG_PCT)) begin
        pgpct_q <= {16'h0, clamp(pg_w[15:8], PGF_LO, PGF_HI), clamp(pg_w[7:0], PGR_LO, PGR_HI)};
      end
      if (wr && (wb_adr_i == A_VIN_LIM)) begin
        vlim_q <= {8'h0, clamp(vl_w[23:16], VOF_LO, VOF_HI), clamp(vl_w[15:8], VON_LO, VON_HI),
                   clamp(vl_w[7:0], VOV_LO, VOV_HI)};
      end
      if (wr && (wb_adr_i == A_RESP)) begin
        resp_q <= {18'h0, (resp_q[13:8] & ~bmask[13:8]) | (wb_dat_i[13:8] & bmask[13:8]),
                   clamp((resp_q[7:0] & ~bmask[7:0]) | (wb_dat_i[7:0] & bmask[7:0]), OT_LO, OT_HI)};
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  wire       en      = ctrl_q[C_EN];
  rfs_resp_e ot_resp, vov_resp, out_resp;
  assign ot_resp  = rfs_resp_e'(resp_q[9:8]);
  assign vov_resp = rfs_resp_e'(resp_q[11:10]);
  assign out_resp = rfs_resp_e'(resp_q[13:12]);

  // ------------------------------------------------------------
  // thresholds and comparisons
  // ------------------------------------------------------------
  wire [23:0] vout100 = 24'(meas_i.vout) * HUNDRED;
  wire        ovw_c   = vout100 > pct_of(vtgt_q[15:0], opct_q[7:0]);
  wire        ovp_c   = vout100 > pct_of(vtgt_q[15:0], opct_q[15:8]);
  wire        uvp_c   = vout100 < pct_of(vtgt_q[15:0], opct_q[23:16]);
  wire        pgr_c   = vout100 >= pct_of(vtgt_q[15:0], pgpct_q[7:0]);
  wire        pgf_c   = vout100 < pct_of(vtgt_q[15:0], pgpct_q[15:8]);
  wire [15:0] vin_ov  = 16'(vlim_q[7:0]) * 16'(PCT_FULL);
  wire [15:0] vin_on  = 16'(vlim_q[15:8]) * 16'(PCT_FULL);
  wire [15:0] vin_off = 16'(vlim_q[23:16]) * 16'(PCT_FULL);
  wire        vov_c   = meas_i.vin > vin_ov;
  wire        von_c   = meas_i.vin > vin_on;
  wire        vuv_c   = meas_i.vin < vin_off;
  wire        ot_c    = tlm_q.temp >= resp_q[7:0];

  // over-voltage filters: a level must persist before it counts
  logic [11:0] fcnt_q [2];
  logic [1:0]  filt_q;
  wire  [1:0]  fraw = {vov_c, ovp_c};
  genvar g;
  for (g = 0; g < 2; g++) begin : g_filt
    always_ff @(posedge clk_i) begin
      if (rst_i || !fraw[g]) begin
        fcnt_q[g] <= 12'h0;
        filt_q[g] <= 1'b0;
      end else if (fcnt_q[g] == T_FILT) begin
        filt_q[g] <= 1'b1;
      end else begin
        fcnt_q[g] <= fcnt_q[g] + 12'h1;
      end
    end
  end
  wire ovp_f = filt_q[0];
  wire vov_f = filt_q[1];

  // ------------------------------------------------------------
  // switching clock and sync
  // ------------------------------------------------------------
  logic [SWW-1:0] sw_cnt_q, per_q, lag_q;
  logic [6:0]     vcnt_q;
  logic           locked_q, lag_run_q, lost_p;
  wire            use_sl  = ctrl_q[C_SLAVE] && !ctrl_q[C_MASTER];
  wire            s_edge  = ctrl_q[C_PH180] ? (sync_d1_q && !sync_s_q) : (sync_s_q && !sync_d1_q);
  wire            in_win  = (per_q >= WIN_LO) && (per_q <= WIN_HI);
  wire            slv_st  = lag_run_q && (lag_q == LAG);
  wire            int_st  = sw_cnt_q == PER;
  wire            cyc_st  = locked_q ? slv_st : int_st;

  always_ff @(posedge clk_i) begin
    if (rst_i || !use_sl) begin
      per_q     <= '0;
      vcnt_q    <= '0;
      locked_q  <= 1'b0;
      lag_run_q <= 1'b0;
      lag_q     <= '0;
      lost_p    <= 1'b0;
    end else begin
      lost_p <= 1'b0;
      per_q  <= s_edge ? '0 : ((per_q > WIN_HI) ? per_q : per_q + 1'b1);
      if (s_edge || per_q > WIN_HI) begin
        if (s_edge && in_win) begin
          if (vcnt_q < VALID_N) vcnt_q <= vcnt_q + 7'h1;
          if (vcnt_q == VALID_N - 7'h1) locked_q <= 1'b1;
        end else begin
          vcnt_q   <= '0;
          locked_q <= 1'b0;
          lost_p   <= locked_q;
        end
      end
      if (s_edge) begin
        lag_run_q <= 1'b1;
        lag_q     <= '0;
      end else if (slv_st) begin
        lag_run_q <= 1'b0;
      end else if (lag_run_q) begin
        lag_q <= lag_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cyc_st) sw_cnt_q <= '0;
    else if (sw_cnt_q != PER) sw_cnt_q <= sw_cnt_q + 1'b1;
    if (rst_i) begin
      sync_o        <= 1'b0;
      sync_oe_o     <= 1'b0;
      cycle_start_o <= 1'b0;
    end else begin
      sync_oe_o     <= ctrl_q[C_MASTER];
      sync_o        <= ctrl_q[C_MASTER] && (cyc_st || (sw_cnt_q < DUTY - 1'b1 && !int_st));
      cycle_start_o <= cyc_st;
    end
  end

  // ------------------------------------------------------------
  // fault detection and sequencing
  // ------------------------------------------------------------
  logic [TW-1:0] tmr_q;
  logic [7:0]    peak_cnt_q;
  logic          cbc_q, pg_ok_q, hold_q, peak_seen_q;
  wire  on_st    = (st_q == S_SOFT_START) || (st_q == S_RUN) || (st_q == S_SOFT_STOP);
  wire  reset_ev = cmp_q.vcc_uv || (on_st && vuv_c) || cmp_q.tshdn;
  wire  start_f  = (st_q == S_SOFT_START) && (tmr_q == T_SS) && uvp_c;
  wire  peak_to  = peak_cnt_q == PEAK_N;
  wire  out_f    = on_st && (ovp_f || (st_q == S_RUN && uvp_c) || cmp_q.avg_oc || cmp_q.sw_node
                   || start_f || peak_to);
  wire  xpk_f    = on_st && cmp_q.hs_extreme;
  wire  vov_prot = on_st && vov_f && ((vov_resp == R_HICCUP) || (vov_resp == R_LATCH));
  wire  ot_prot  = on_st && ot_c && ((ot_resp == R_HICCUP) || (ot_resp == R_LATCH));
  wire  latch_go = ((out_f || xpk_f) && out_resp == R_LATCH) || (vov_prot && vov_resp == R_LATCH)
                   || (ot_prot && ot_resp == R_LATCH);
  wire  prot_go  = ((out_f || xpk_f) && out_resp != R_IGNORE) || xpk_f || vov_prot || ot_prot;
  wire  hold_c   = (vov_f && vov_resp == R_RECOVER) || (ot_c && ot_resp == R_RECOVER);
  wire  tmr_end  = (st_q == S_SOFT_START || st_q == S_SOFT_STOP) ? (tmr_q == T_SS) :
                   (tmr_q == T_HIC);
  rfs_st_e st_d;

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_OFF:        if (en && von_c && !cmp_q.vcc_uv && !cmp_q.tshdn && !hold_c) st_d = S_SOFT_START;
      S_SOFT_START: if (tmr_end && !start_f) st_d = S_RUN;
      S_RUN:        if (!en) st_d = S_SOFT_STOP;
      S_SOFT_STOP:  if (tmr_end) st_d = S_OFF;
      S_HICCUP:     if (tmr_end) st_d = S_OFF;
      S_LATCHED:    if (clr_p || !en) st_d = S_OFF;
      default:      st_d = S_OFF;
    endcase
    if (prot_go) st_d = latch_go ? S_LATCHED : S_HICCUP;
    if (reset_ev && st_q != S_LATCHED) st_d = S_OFF;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= S_OFF;
      tmr_q       <= '0;
      peak_cnt_q  <= '0;
      cbc_q       <= 1'b0;
      peak_seen_q <= 1'b0;
      hold_q      <= 1'b0;
      pg_ok_q     <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= (st_d != st_q || tmr_end) ? '0 : tmr_q + 1'b1;
      hold_q <= hold_c;
      if (pgr_c) pg_ok_q <= 1'b1;
      else if (pgf_c) pg_ok_q <= 1'b0;
      if (cyc_st) begin
        cbc_q       <= 1'b0;
        peak_seen_q <= 1'b0;
        peak_cnt_q  <= (peak_seen_q && on_st) ? (peak_to ? peak_cnt_q : peak_cnt_q + 8'h1) : '0;
      end else if (cmp_q.hs_peak) begin
        cbc_q       <= 1'b1;
        peak_seen_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // switch enables and power good
  // ------------------------------------------------------------
  wire ovw_act  = on_st && ovw_c;
  wire sw_act   = on_st && !hold_q && !ovw_act;
  wire boot_rf  = on_st && cmp_q.boot_uv && (sw_cnt_q < BOOT_N);
  wire pull_dn  = ovw_act && ctrl_q[C_PULLDN];
  wire hs_d     = sw_act && !cmp_q.boot_uv && !cbc_q && !cyc_st;
  wire ls_d     = (sw_act && !cmp_q.boot_uv) || boot_rf || pull_dn;
  wire pg_d     = (st_q == S_RUN) && pg_ok_q && !ovp_c;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_side_switch_o  <= 1'b0;
      low_side_switch_o   <= 1'b0;
      power_good_output_o <= 1'b0;
      bias_off_o          <= 1'b0;
    end else begin
      high_side_switch_o  <= hs_d;
      low_side_switch_o   <= ls_d;
      power_good_output_o <= pg_d;
      bias_off_o          <= cmp_q.tshdn;
    end
  end

  // ------------------------------------------------------------
  // telemetry snapshot and sticky status
  // ------------------------------------------------------------
  logic [TW-1:0] tlm_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tlm_cnt_q <= '0;
      tlm_q     <= '0;
    end else begin
      tlm_cnt_q <= (tlm_cnt_q == T_TLM - 1'b1) ? '0 : tlm_cnt_q + 1'b1;
      if (tlm_cnt_q == T_TLM - 1'b1) tlm_q <= meas_i;
    end
  end

  always_comb begin
    ev           = '0;
    ev[F_OVW]    = ovw_act;
    ev[F_OVP]    = ovp_f;
    ev[F_UVP]    = st_q == S_RUN && uvp_c;
    ev[F_VIN_OV] = vov_f;
    ev[F_VIN_UV] = on_st && vuv_c;
    ev[F_VCC_UV] = cmp_q.vcc_uv;
    ev[F_OT]     = ot_c;
    ev[F_TSHDN]  = cmp_q.tshdn;
    ev[F_BOOT]   = cmp_q.boot_uv;
    ev[F_AVG]    = cmp_q.avg_oc;
    ev[F_PEAK]   = cmp_q.hs_peak;
    ev[F_XPEAK]  = cmp_q.hs_extreme;
    ev[F_SWN]    = cmp_q.sw_node;
    ev[F_START]  = start_f;
    ev[F_SYNC]   = lost_p;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) stat_q <= '0;
    else stat_q <= (stat_q & ~st_clr[NFLAG-1:0]) | ev;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int LAG_D = SYNC_LAG_CYC + 2;
  AST_OVW_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    ovw_act |=> !high_side_switch_o) else $error("switching not halted on warning");
  AST_OVW_LS: assert property (@(posedge clk_i) disable iff (rst_i)
    ovw_act && !ctrl_q[C_PULLDN] && !boot_rf |=> !low_side_switch_o)
    else $error("low side on during warning");
  AST_PG_SS: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == S_SOFT_START || st_q == S_SOFT_STOP) |=> !power_good_output_o)
    else $error("power good high in soft phase");
  AST_PG_OVP: assert property (@(posedge clk_i) disable iff (rst_i)
    ovp_c |=> !power_good_output_o) else $error("power good high above protection");
  AST_PG_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == S_RUN && pg_ok_q && !ovp_c |=> power_good_output_o) else $error("power good missing");
  AST_LAG: assert property (@(posedge clk_i) disable iff (rst_i)
    locked_q && s_edge && use_sl |-> ##LAG_D (cycle_start_o || !locked_q))
    else $error("slave lag wrong");
  AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(locked_q) |-> vcnt_q == VALID_N) else $error("locked too early");
  AST_TSHDN: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_q.tshdn |=> st_q == S_OFF || st_q == S_LATCHED) else $error("no thermal cutoff");
  AST_BOOT: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_q.boot_uv |=> !high_side_switch_o) else $error("high side on with boot low");
  AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[F_OT] |=> stat_q[F_OT]) else $error("flag lost");
endmodule

/* File: tb/rfs_peer.sv */
`timescale 1ns/1ps
module rfs_peer #(
  parameter int HALF  = 1100,
  parameter int PHASE = 1
) (
  input  wire logic en_i,
  output logic      sync_o
);
  logic started = 1'b0;
  // peer master clock; stays low while the link is idle
  always begin
    sync_o = 1'b0;
    wait (en_i);
    // one-time offset keeps peer edges away from the bench clock edges
    if (!started) begin
      started = 1'b1;
      #(PHASE);
    end
    #(HALF) sync_o = 1'b1;
    #(HALF);
  end
endmodule

/* File: tb/tb_rfs_top.sv */
`timescale 1ns/1ps
module tb_rfs_top;
  import rfs_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sync_en = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic        ack, sync_o, sync_oe, hs, ls, cs, pg, boff, peer_sync;
  rfs_cmp_s    cmp = '0;
  rfs_meas_s   meas = '0;
  int          num_errors = 0, comparisons = 0, n, vin;
  always #2 clk_i = ~clk_i;
  rfs_top #(.SS_CYC(50), .TELEM_CYCP(100), .HICCUP_P(200)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_i(cmp), .meas_i(meas), .sync_i(peer_sync), .sync_o(sync_o), .sync_oe_o(sync_oe),
    .high_side_switch_o(hs), .low_side_switch_o(ls), .cycle_start_o(cs),
    .power_good_output_o(pg), .bias_off_o(boff));
  rfs_peer #(.HALF(1100)) i_peer (.en_i(sync_en), .sync_o(peer_sync));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cyc_n(input int c);
    repeat (c) @(negedge clk_i);
  endtask
  // cycles between two cycle start pulses
  task automatic gap(output int g);
    g = 0;
    while (cs !== 1'b1 && g < 2000) begin cyc_n(1); g++; end
    cyc_n(1);
    g = 1;
    while (cs !== 1'b1 && g < 2000) begin cyc_n(1); g++; end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #250000;
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'hb62e09f1));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(0, A_CTRL, 0); chk(q, RST_CTRL);
    wb(0, 8'hfc, 0); chk(q, 0);
    wb(1, A_OUT_PCT, 32'h0037_6e00); wb(0, A_OUT_PCT, 0); chk(q, RST_OUT_PCT);
    // one target write that leaves the reset value in place, settled before anything else touches it
    wb(1, A_VOUT_TGT, 32'hffff_0320); wb(0, A_VOUT_TGT, 0); chk(q, RST_VOUT);
    vin = 5000 + $urandom_range(7000);
    meas.vin <= vin[15:0];
    meas.vout <= 16'd800;
    repeat (40) begin cyc_n(1); chk(pg, 0); end
    cyc_n(30); chk(pg, 1);
    @(posedge clk_i);
    meas.vout <= 16'd880;
    cyc_n(6); chk({hs, ls, pg}, 3'b001);
    wb(1, A_CTRL, 32'h3); cyc_n(6); chk(ls, 1);
    @(posedge clk_i);
    meas.vout <= 16'd920;
    cyc_n(6); chk(pg, 0);
    cyc_n(1400);
    @(posedge clk_i);
    meas.vout <= 16'd800;
    wb(0, A_STATUS, 0); chk(q[1:0], 2'b11);
    cyc_n(10); wb(1, A_STATUS, 32'hffff_ffff); wb(0, A_STATUS, 0); chk(q[1:0], 0);
    @(posedge clk_i);
    cmp.tshdn <= 1;
    cyc_n(6); chk({boff, hs, ls, pg}, 4'b1000);
    @(posedge clk_i);
    cmp.tshdn <= 0;
    wb(1, A_CTRL, 32'h5);
    cyc_n(1);
    // skip a high phase already under way when master mode came on
    n = 0;
    while (sync_o === 1'b1 && n < 2000) begin cyc_n(1); n++; end
    while (sync_o !== 1'b1 && n < 2000) begin cyc_n(1); n++; end
    chk({cs, sync_oe}, 2'b11);
    n = 0;
    while (sync_o === 1'b1 && n < 2000) begin cyc_n(1); n++; end
    chk(n, 225);
    wb(1, A_CTRL, 32'h11); sync_en <= 1;
    repeat (75 * 550) @(posedge clk_i);
    gap(n); chk(n, 550);
    // falling edges fall mid-period: lock is lost, internal clock returns
    wb(1, A_CTRL, 32'h19);
    cyc_n(1200);
    wb(0, A_STATUS, 0); chk(q[F_SYNC], 1);
    gap(n); chk(n, 500);
    wb(0, A_TLM_V, 0); chk(q, {16'd800, vin[15:0]});
    conclude();
  end
endmodule
